// >>> sfpi_front.sv
// Pin front end of the serial flash: framing, pause, line direction
module sfpi_front (
  input  wire logic              CLK_IN,
  input  wire logic              NRST_IN,
  input  wire logic              SCLK_IN,
  input  wire logic              CS_N_IN,
  input  wire logic [3:0]        IO_LINE_IN,
  output logic [3:0]             IO_LINE_OUT,
  output logic [3:0]             IO_LINE_OE_OUT,
  input  wire logic              QUAD_IO_ENABLE_BIT_IN,
  input  wire logic              FOUR_LINE_COMMAND_MODE_IN,
  input  sfpi_pkg::sfpi_prot_t   PROT_IN,
  input  sfpi_pkg::sfpi_width_t  ADDR_WIDTH_IN,
  input  sfpi_pkg::sfpi_width_t  DATA_WIDTH_IN,
  input  wire logic              READ_PHASE_IN,
  input  wire logic [7:0]        READ_BYTE_IN,
  input  wire logic              INTERNAL_BUSY_IN,
  output logic                   READ_BYTE_TAKE_OUT,
  output logic [7:0]             OPCODE_OUT,
  output logic                   OPCODE_VALID_OUT,
  output logic                   OPCODE_REJECT_OUT,
  output logic [7:0]             RX_BYTE_OUT,
  output logic                   RX_BYTE_VALID_OUT,
  output logic                   PROGRAM_OVERRUN_OUT,
  output logic                   SELECTED_OUT,
  output logic                   PAUSED_OUT,
  output logic                   STATUS_WRITE_OK_OUT,
  output logic                   ARRAY_PROT_ACTIVE_OUT,
  output logic                   INTERNAL_BUSY_OUT
);
  //----------------------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------------------
  logic                  sclk_lvl;
  sfpi_pkg::sfpi_edge_t  sclk_edge;
  logic                  cs_n_lvl;
  sfpi_pkg::sfpi_edge_t  cs_edge;
  logic [3:0]            io_sync;
  logic                  armed_reg;
  logic                  op_done_reg;
  logic [7:0]            shift_reg;
  logic [3:0]            bit_cnt_reg;
  logic [8:0]            prog_cnt_reg;
  logic [7:0]            tx_reg;
  logic [3:0]            tx_cnt_reg;
  logic [3:0]            out_reg;
  logic [3:0]            oe_reg;
  logic [7:0]            opcode_reg;
  logic                  opv_reg;
  logic                  rej_reg;
  logic [7:0]            rx_reg;
  logic                  rxv_reg;
  logic                  ovr_reg;
  logic                  pause_act;
  logic                  active;
  sfpi_pkg::sfpi_width_t rx_width;
  logic [3:0]            step;
  logic [7:0]            shift_next;
  logic [3:0]            bit_cnt_next;

  // Bits moved per clock edge for a width
  function automatic logic [3:0] sfpi_step(input sfpi_pkg::sfpi_width_t w);
    unique case (w)
      sfpi_pkg::SFPI_W_SINGLE: sfpi_step = 4'h1;
      sfpi_pkg::SFPI_W_DUAL:   sfpi_step = 4'h2;
      sfpi_pkg::SFPI_W_QUAD:   sfpi_step = 4'h4;
      default:                 sfpi_step = 4'h0;
    endcase
  endfunction : sfpi_step

  // Shift in the lines the width uses
  function automatic logic [7:0] sfpi_shift(input logic [7:0] s,
                                            input sfpi_pkg::sfpi_width_t w,
                                            input logic [3:0] d);
    unique case (w)
      sfpi_pkg::SFPI_W_SINGLE: sfpi_shift = {s[6:0], d[0]};
      sfpi_pkg::SFPI_W_DUAL:   sfpi_shift = {s[5:0], d[1:0]};
      sfpi_pkg::SFPI_W_QUAD:   sfpi_shift = {s[3:0], d[3:0]};
      default:                 sfpi_shift = s;
    endcase
  endfunction : sfpi_shift

  //----------------------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------------------
  sfpi_sync u_sclk (
    .CLK_IN       (CLK_IN),
    .NRST_IN      (NRST_IN),
    .PIN_IN       (SCLK_IN),
    .RESET_VAL_IN (1'b0),
    .LEVEL_OUT    (sclk_lvl),
    .EDGE_OUT     (sclk_edge)
  );

  sfpi_sync u_cs (
    .CLK_IN       (CLK_IN),
    .NRST_IN      (NRST_IN),
    .PIN_IN       (CS_N_IN),
    .RESET_VAL_IN (1'b1),
    .LEVEL_OUT    (cs_n_lvl),
    .EDGE_OUT     (cs_edge)
  );

  genvar gi;
  generate
    for (gi = 0; gi < sfpi_pkg::SFPI_LINES; gi++) begin : g_io
      sfpi_sync u_io (
        .CLK_IN       (CLK_IN),
        .NRST_IN      (NRST_IN),
        .PIN_IN       (IO_LINE_IN[gi]),
        .RESET_VAL_IN (1'b1),
        .LEVEL_OUT    (io_sync[gi]),
        .EDGE_OUT     ()
      );
    end
  endgenerate

  //----------------------------------------------------------------------------
  // Status write guard
  //----------------------------------------------------------------------------
  sfpi_prot u_prot (
    .CLK_IN                (CLK_IN),
    .NRST_IN               (NRST_IN),
    .WP_N_SYNC_IN          (io_sync[2]),
    .QUAD_EN_IN            (QUAD_IO_ENABLE_BIT_IN),
    .PROT_IN               (PROT_IN),
    .STATUS_WRITE_OK_OUT   (STATUS_WRITE_OK_OUT),
    .ARRAY_PROT_ACTIVE_OUT (ARRAY_PROT_ACTIVE_OUT)
  );

  //----------------------------------------------------------------------------
  // Framing and pause
  //----------------------------------------------------------------------------
  // Pause acts only while selected and quad enable clear
  assign pause_act = !cs_n_lvl && !io_sync[3] && !QUAD_IO_ENABLE_BIT_IN;
  assign active    = !cs_n_lvl && armed_reg && !pause_act;

  // Power-up arming by the first select falling edge
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      armed_reg <= 1'b0;
    end else if (cs_edge.fall) begin
      armed_reg <= 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // Receive path
  //----------------------------------------------------------------------------
  // Width of the current receive phase
  always_comb begin
    if (!op_done_reg) begin
      rx_width = FOUR_LINE_COMMAND_MODE_IN ? sfpi_pkg::SFPI_W_QUAD
                                           : sfpi_pkg::SFPI_W_SINGLE;
    end else if (READ_PHASE_IN) begin
      rx_width = sfpi_pkg::SFPI_W_NONE;
    end else begin
      rx_width = DATA_WIDTH_IN;
    end
    step         = sfpi_step(rx_width);
    shift_next   = sfpi_shift(shift_reg, rx_width, io_sync);
    bit_cnt_next = bit_cnt_reg + step;
  end

  // Rising clock edges shift data in; state survives pause
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 4'h0;
      op_done_reg <= 1'b0;
      opcode_reg  <= 8'h00;
      opv_reg     <= 1'b0;
      rej_reg     <= 1'b0;
      rx_reg      <= 8'h00;
      rxv_reg     <= 1'b0;
    end else begin
      opv_reg <= 1'b0;
      rej_reg <= 1'b0;
      rxv_reg <= 1'b0;
      if (cs_n_lvl) begin
        bit_cnt_reg <= 4'h0;
        op_done_reg <= 1'b0;
      end else if (active && sclk_edge.rise && step != 4'h0) begin
        shift_reg <= shift_next;
        if (bit_cnt_next >= sfpi_pkg::SFPI_BITS_BYTE) begin
          bit_cnt_reg <= 4'h0;
          if (!op_done_reg) begin
            op_done_reg <= 1'b1;
            opcode_reg  <= shift_next;
            // Four-line opcodes need quad enable
            if (FOUR_LINE_COMMAND_MODE_IN && !QUAD_IO_ENABLE_BIT_IN) begin
              rej_reg <= 1'b1;
            end else begin
              opv_reg <= 1'b1;
            end
          end else begin
            rx_reg  <= shift_next;
            rxv_reg <= 1'b1;
          end
        end else begin
          bit_cnt_reg <= bit_cnt_next;
        end
      end
    end
  end

  // Program byte count within one frame
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      prog_cnt_reg <= 9'h000;
      ovr_reg      <= 1'b0;
    end else if (cs_n_lvl) begin
      prog_cnt_reg <= 9'h000;
      ovr_reg      <= 1'b0;
    end else if (rxv_reg) begin
      if (prog_cnt_reg == sfpi_pkg::SFPI_PAGE_MAX) begin
        ovr_reg <= 1'b1;
      end else begin
        prog_cnt_reg <= prog_cnt_reg + 9'h001;
      end
    end
  end

  //----------------------------------------------------------------------------
  // Transmit path
  //----------------------------------------------------------------------------
  // Falling clock edges update output lines
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx_reg     <= 8'h00;
      tx_cnt_reg <= 4'h0;
      out_reg    <= 4'h0;
      oe_reg     <= 4'h0;
    end else if (cs_n_lvl) begin
      tx_cnt_reg <= 4'h0;
      oe_reg     <= 4'h0;
    end else if (pause_act) begin
      oe_reg <= 4'h0;
    end else if (active && READ_PHASE_IN && op_done_reg && sclk_edge.fall) begin
      unique case (DATA_WIDTH_IN)
        sfpi_pkg::SFPI_W_SINGLE: begin
          // Single mode answers on line 1 only; line 0 stays an input
          out_reg <= {2'h0, ((tx_cnt_reg == 4'h0) ? READ_BYTE_IN[7] : tx_reg[7]), 1'b0};
          oe_reg  <= 4'h2;
        end
        sfpi_pkg::SFPI_W_DUAL: begin
          out_reg <= {2'h0, (tx_cnt_reg == 4'h0) ? READ_BYTE_IN[7:6] : tx_reg[7:6]};
          oe_reg  <= 4'h3;
        end
        default: begin
          out_reg <= (tx_cnt_reg == 4'h0) ? READ_BYTE_IN[7:4] : tx_reg[7:4];
          oe_reg  <= QUAD_IO_ENABLE_BIT_IN ? 4'hF : 4'h0;
        end
      endcase
      if (tx_cnt_reg == 4'h0) begin
        tx_reg <= READ_BYTE_IN << sfpi_step(DATA_WIDTH_IN);
      end else begin
        tx_reg <= tx_reg << sfpi_step(DATA_WIDTH_IN);
      end
      tx_cnt_reg <= (tx_cnt_reg + sfpi_step(DATA_WIDTH_IN) >= sfpi_pkg::SFPI_BITS_BYTE)
                    ? 4'h0 : tx_cnt_reg + sfpi_step(DATA_WIDTH_IN);
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign READ_BYTE_TAKE_OUT  = active && READ_PHASE_IN && op_done_reg
                               && sclk_edge.fall && (tx_cnt_reg == 4'h0);
  assign IO_LINE_OUT         = out_reg;
  assign IO_LINE_OE_OUT      = oe_reg;
  assign OPCODE_OUT          = opcode_reg;
  assign OPCODE_VALID_OUT    = opv_reg;
  assign OPCODE_REJECT_OUT   = rej_reg;
  assign RX_BYTE_OUT         = rx_reg;
  assign RX_BYTE_VALID_OUT   = rxv_reg;
  assign PROGRAM_OVERRUN_OUT = ovr_reg;
  assign SELECTED_OUT        = !cs_n_lvl && armed_reg;
  assign PAUSED_OUT          = pause_act;
  // Internal cycle runs on regardless of select
  assign INTERNAL_BUSY_OUT   = INTERNAL_BUSY_IN;

  logic unused_ok;
  assign unused_ok = sclk_lvl ^ (ADDR_WIDTH_IN == sfpi_pkg::SFPI_W_NONE);
endmodule : sfpi_front

// >>> sfpi_pkg.sv
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package sfpi_pkg;

  //----------------------------------------------------------------------------
  // Constants
  //----------------------------------------------------------------------------
  localparam int          SFPI_LINES      = 4;
  localparam int          SFPI_PAGE_BYTES = 256;
  localparam logic [8:0]  SFPI_PAGE_MAX   = 9'h100;
  localparam logic [3:0]  SFPI_BITS_BYTE  = 4'h8;
  localparam logic [1:0]  SFPI_LOCK_HW    = 2'h1;
  localparam logic [2:0]  SFPI_RANGE_NONE = 3'h0;

  // Transfer width of the current phase
  typedef enum logic [3:0] {
    SFPI_W_SINGLE = 4'b0001,
    SFPI_W_DUAL   = 4'b0010,
    SFPI_W_QUAD   = 4'b0100,
    SFPI_W_NONE   = 4'b1000
  } sfpi_width_t;

  // Protection bits from the status registers
  typedef struct packed {
    logic [1:0] status_lock_bits;
    logic       complement_protect_bit;
    logic       small_unit_protect_bit;
    logic       top_bottom_select_bit;
    logic [2:0] protect_range;
  } sfpi_prot_t;

  // Four two-way data lines as two signals, output and enable
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } sfpi_drive_t;

  // Detected edges of a sampled pin (link clock or chip select)
  typedef struct packed {
    logic rise;
    logic fall;
  } sfpi_edge_t;

endpackage : sfpi_pkg

// >>> sfpi_sync.sv
// Two-flop synchroniser with edge detection of the stable copy
module sfpi_sync (
  input  wire logic              CLK_IN,
  input  wire logic              NRST_IN,
  input  wire logic              PIN_IN,
  input  wire logic              RESET_VAL_IN,
  output logic                   LEVEL_OUT,
  output sfpi_pkg::sfpi_edge_t   EDGE_OUT
);
  logic meta_reg;
  logic stab_reg;
  logic prev_reg;
  logic [2:0] live_reg;

  //----------------------------------------------------------------------------
  // Synchroniser chain
  //----------------------------------------------------------------------------
  // First stage feeds only the second
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      meta_reg <= 1'b1;
      stab_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= PIN_IN;
      stab_reg <= meta_reg;
      prev_reg <= stab_reg;
    end
  end

  // Edges count only once the history flop holds a real pin sample,
  // so a pin already low at wake-up gives no false edge
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      live_reg <= 3'h0;
    end else begin
      live_reg <= {live_reg[1:0], 1'b1};
    end
  end

  assign LEVEL_OUT     = stab_reg;
  assign EDGE_OUT.rise = live_reg[2] & stab_reg & ~prev_reg;
  assign EDGE_OUT.fall = live_reg[2] & ~stab_reg & prev_reg;

  // Reset value input kept for symmetry of chain use
  logic unused_ok;
  assign unused_ok = RESET_VAL_IN;
endmodule : sfpi_sync

// >>> sfpi_prot.sv
// Status write guard from protect pin and lock bits
module sfpi_prot (
  input  wire logic              CLK_IN,
  input  wire logic              NRST_IN,
  input  wire logic              WP_N_SYNC_IN,
  input  wire logic              QUAD_EN_IN,
  input  sfpi_pkg::sfpi_prot_t   PROT_IN,
  output logic                   STATUS_WRITE_OK_OUT,
  output logic                   ARRAY_PROT_ACTIVE_OUT
);
  logic hw_block;

  // Protect pin counts only while not a data line
  assign hw_block = !QUAD_EN_IN && !WP_N_SYNC_IN
                    && (PROT_IN.status_lock_bits == sfpi_pkg::SFPI_LOCK_HW);

  //----------------------------------------------------------------------------
  // Registered guard outputs
  //----------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      STATUS_WRITE_OK_OUT   <= 1'b0;
      ARRAY_PROT_ACTIVE_OUT <= 1'b0;
    end else begin
      STATUS_WRITE_OK_OUT   <= !hw_block;
      // Any nonzero range or the complement bit protects some region
      ARRAY_PROT_ACTIVE_OUT <= (PROT_IN.protect_range != sfpi_pkg::SFPI_RANGE_NONE)
                               || PROT_IN.complement_protect_bit;
    end
  end
endmodule : sfpi_prot

// >>> sfpi_front_asserts.sv
// Port-level checker for the serial flash pin front end
module sfpi_front_asserts (
  input wire logic             CLK_IN,
  input wire logic             NRST_IN,
  input wire logic             CS_N_IN,
  input wire logic [3:0]       IO_LINE_IN,
  input wire logic [3:0]       IO_LINE_OE_OUT,
  input wire logic             QUAD_IO_ENABLE_BIT_IN,
  input sfpi_pkg::sfpi_prot_t  PROT_IN,
  input sfpi_pkg::sfpi_width_t DATA_WIDTH_IN,
  input wire logic             INTERNAL_BUSY_IN,
  input wire logic             OPCODE_VALID_OUT,
  input wire logic             OPCODE_REJECT_OUT,
  input wire logic             RX_BYTE_VALID_OUT,
  input wire logic             SELECTED_OUT,
  input wire logic             PAUSED_OUT,
  input wire logic             STATUS_WRITE_OK_OUT,
  input wire logic             INTERNAL_BUSY_OUT
);
  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // Pin relations, allowing for the synchroniser delay
  a_desel_float: assert property (CS_N_IN [*5] |-> IO_LINE_OE_OUT == 4'h0)
    else $error("line driven while deselected");
  a_single_in: assert property (DATA_WIDTH_IN == sfpi_pkg::SFPI_W_SINGLE |-> !IO_LINE_OE_OUT[0])
    else $error("input line driven in single mode");
  a_dual_lines: assert property (DATA_WIDTH_IN == sfpi_pkg::SFPI_W_DUAL |-> IO_LINE_OE_OUT[3:2] == 2'h0)
    else $error("upper lines driven in dual mode");
  a_quad_nopause: assert property (QUAD_IO_ENABLE_BIT_IN [*3] |-> !PAUSED_OUT)
    else $error("pause active with quad enable");
  a_pause_float: assert property (PAUSED_OUT [*3] |-> IO_LINE_OE_OUT == 4'h0)
    else $error("line driven during pause");
  a_busy_kept: assert property (INTERNAL_BUSY_IN && CS_N_IN |-> INTERNAL_BUSY_OUT)
    else $error("internal cycle dropped at deselect");
  a_wp_block: assert property ((PROT_IN.status_lock_bits == sfpi_pkg::SFPI_LOCK_HW
    && !IO_LINE_IN[2] && !QUAD_IO_ENABLE_BIT_IN) [*5] |-> !STATUS_WRITE_OK_OUT)
    else $error("status write allowed while protected");
  a_qe_nowp: assert property (QUAD_IO_ENABLE_BIT_IN [*5] |-> STATUS_WRITE_OK_OUT)
    else $error("protect pin honoured with quad enable");
  a_rx_selected: assert property (OPCODE_VALID_OUT || RX_BYTE_VALID_OUT |-> SELECTED_OUT)
    else $error("byte accepted while deselected");
  a_op_pulse: assert property (OPCODE_VALID_OUT |=> !OPCODE_VALID_OUT && !OPCODE_REJECT_OUT)
    else $error("opcode strobe longer than one cycle");
  // Main scenarios reached
  c_opcode: cover property (OPCODE_VALID_OUT);
  c_reject: cover property (OPCODE_REJECT_OUT);
  c_pause: cover property (PAUSED_OUT);
  c_rx: cover property (RX_BYTE_VALID_OUT);
endmodule : sfpi_front_asserts

bind sfpi_front sfpi_front_asserts i_sfpi_front_asserts (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN),
  .CS_N_IN(CS_N_IN), .IO_LINE_IN(IO_LINE_IN), .IO_LINE_OE_OUT(IO_LINE_OE_OUT),
  .QUAD_IO_ENABLE_BIT_IN(QUAD_IO_ENABLE_BIT_IN), .PROT_IN(PROT_IN),
  .DATA_WIDTH_IN(DATA_WIDTH_IN), .INTERNAL_BUSY_IN(INTERNAL_BUSY_IN),
  .OPCODE_VALID_OUT(OPCODE_VALID_OUT), .OPCODE_REJECT_OUT(OPCODE_REJECT_OUT),
  .RX_BYTE_VALID_OUT(RX_BYTE_VALID_OUT), .SELECTED_OUT(SELECTED_OUT),
  .PAUSED_OUT(PAUSED_OUT), .STATUS_WRITE_OK_OUT(STATUS_WRITE_OK_OUT),
  .INTERNAL_BUSY_OUT(INTERNAL_BUSY_OUT));

// >>> sfpi_host.sv
// Link host: makes the link clock, chip select and host line drive
module sfpi_host (
  input  wire logic       clk_in,
  input  wire logic [3:0] line_in,
  output logic            sclk_out,
  output logic            cs_n_out,
  output logic [3:0]      drv_out,
  output logic [3:0]      oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  //----------------------------------------------------------------------------
  // Link tasks
  //----------------------------------------------------------------------------
  // Idle: clock low and still, chip select high from power-up
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    drv_out  = 4'h0;
    oe_out   = 4'h0;
  end
  // Half link period of 24 ns
  task automatic half();
    repeat (6) @(negedge clk_in);
  endtask : half
  // One link clock: lines set while low, read back at the rise
  task automatic beat(input logic [3:0] d, input logic [3:0] m, output logic [3:0] q);
    drv_out = d;
    oe_out = m;
    half();
    sclk_out = 1'b1;
    q = line_in;
    half();
    sclk_out = 1'b0;
  endtask : beat
  task automatic select();
    cs_n_out = 1'b0;
    half();
  endtask : select
  task automatic deselect();
    oe_out = 4'h0;
    half();
    cs_n_out = 1'b1;
    half();
  endtask : deselect
  // Pause pin low with junk clocks on line 0, then released
  task automatic pause();
    logic [3:0] s;
    drv_out = 4'h0;
    oe_out = 4'h9;
    half();
    for (int i = 0; i < 3; i++) beat({3'h0, i[0]}, 4'h9, s);
    oe_out = 4'h1;
    half();
  endtask : pause
  // One byte MSB first over 1, 2 or 4 lines; rd releases all lines
  task automatic xfer(input logic [7:0] b, input int ln, input logic rd, input int pa,
                      output logic [7:0] q);
    logic [3:0] d;
    logic [3:0] m;
    logic [3:0] s;
    m = (ln == 4) ? 4'hF : (ln == 2) ? 4'h3 : 4'h1;
    q = 8'h00;
    for (int i = 0; i < 8 / ln; i++) begin
      if (i == pa) pause();
      d = (ln == 4) ? b[7:4] : (ln == 2) ? {2'h0, b[7:6]} : {3'h0, b[7]};
      b = b << ln;
      beat(d, rd ? 4'h0 : m, s);
      q = (ln == 4) ? {q[3:0], s} : (ln == 2) ? {q[5:0], s[1:0]} : {q[6:0], s[1]};
    end
  endtask : xfer
endmodule : sfpi_host

// >>> sfpi_tb.sv
// Self-checking bench of the pin front end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  //----------------------------------------------------------------------------
  // Signals and instances
  //----------------------------------------------------------------------------
  logic clk = 1'b0, rst_n, qe, four, rd_ph, busy, wp_lvl, tog = 1'b0, saw_pause = 1'b0;
  logic sclk, cs_n, op_v, op_r, rx_v, ovr, sel, paused, wok, aprot, busy_o, tk, saw_take = 1'b0;
  logic [3:0] line, dev_out, dev_oe, h_drv, h_oe;
  logic [7:0] rd_byte, opcode, rx, q;
  logic [9:0] got, exp_q[$];
  logic [31:0] seed = 32'h0000004E;
  sfpi_pkg::sfpi_prot_t prot;
  sfpi_pkg::sfpi_width_t dw;
  int n_fail = 0, n_tests = 0;
  // Lines 3:2 pulled up (2 via board jumper), 1:0 float to a moving pattern
  assign line = (dev_oe & dev_out) | (~dev_oe & h_oe & h_drv)
              | (~dev_oe & ~h_oe & {1'b1, wp_lvl, tog, ~tog});
  always #2 clk = ~clk;
  always @(negedge clk) tog <= ~tog;
  sfpi_host i_sfpi_host (.clk_in(clk), .line_in(line), .sclk_out(sclk), .cs_n_out(cs_n),
    .drv_out(h_drv), .oe_out(h_oe));
  sfpi_front i_sfpi_front (.CLK_IN(clk), .NRST_IN(rst_n), .SCLK_IN(sclk), .CS_N_IN(cs_n),
    .IO_LINE_IN(line), .IO_LINE_OUT(dev_out), .IO_LINE_OE_OUT(dev_oe),
    .QUAD_IO_ENABLE_BIT_IN(qe), .FOUR_LINE_COMMAND_MODE_IN(four), .PROT_IN(prot),
    .ADDR_WIDTH_IN(sfpi_pkg::SFPI_W_SINGLE), .DATA_WIDTH_IN(dw), .READ_PHASE_IN(rd_ph),
    .READ_BYTE_IN(rd_byte), .INTERNAL_BUSY_IN(busy), .READ_BYTE_TAKE_OUT(tk),
    .OPCODE_OUT(opcode), .OPCODE_VALID_OUT(op_v), .OPCODE_REJECT_OUT(op_r),
    .RX_BYTE_OUT(rx), .RX_BYTE_VALID_OUT(rx_v), .PROGRAM_OVERRUN_OUT(ovr),
    .SELECTED_OUT(sel), .PAUSED_OUT(paused), .STATUS_WRITE_OK_OUT(wok),
    .ARRAY_PROT_ACTIVE_OUT(aprot), .INTERNAL_BUSY_OUT(busy_o));
  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic cmp(input string nm, input logic [9:0] e, input logic [9:0] s);
    n_tests++;
    if (e !== s) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // Frame: opcode of kind kd, then n data bytes; pause on the first at beat pa
  task automatic frame(input logic [7:0] op, input int lo, input int ld, input int n,
                       input logic [1:0] kd, input int pa);
    logic [7:0] b;
    i_sfpi_host.select();
    exp_q.push_back({kd, kd[1] ? 8'h00 : op});
    i_sfpi_host.xfer(op, lo, 1'b0, -1, q);
    for (int i = 0; i < n; i++) begin
      b = rnd();
      exp_q.push_back({2'h1, b});
      i_sfpi_host.xfer(b, ld, 1'b0, (i == 0) ? pa : -1, q);
    end
  endtask : frame
  // Oldest expectation against every strobe that appears
  always @(negedge clk) begin
    if ((op_v | rx_v | op_r) === 1'b1) begin
      got = {op_r ? 2'h2 : rx_v ? 2'h1 : 2'h0, op_r ? 8'h00 : rx_v ? rx : opcode};
      cmp("byte stream", (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3FF, got);
    end
    if (paused === 1'b1) saw_pause = 1'b1;
    if (tk === 1'b1) saw_take = 1'b1;
  end
  //----------------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------------
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
  initial begin
    {rst_n, qe, four, rd_ph, busy, wp_lvl, rd_byte, prot} = {6'h01, 8'h00, 8'h00};
    dw = sfpi_pkg::SFPI_W_SINGLE;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    // Select already low at wake-up: the device stays unarmed and silent
    i_sfpi_host.select();
    i_sfpi_host.xfer(rnd(), 1, 1'b0, -1, q);
    cmp("armed early", 10'h000, {9'h000, sel});
    i_sfpi_host.deselect();
    for (int k = 0; k < 3; k++) begin
      dw = (k == 0) ? sfpi_pkg::SFPI_W_SINGLE : (k == 1) ? sfpi_pkg::SFPI_W_DUAL
         : sfpi_pkg::SFPI_W_QUAD;
      qe = (k == 2);
      frame(rnd(), 1, 1 << k, 2, 2'h0, -1);
      i_sfpi_host.deselect();
    end
    four = 1'b1;
    frame(rnd(), 4, 4, 1, 2'h0, -1);
    i_sfpi_host.deselect();
    qe = 1'b0;
    // Line 3 kept high in the opcode so the pause pin stays idle
    frame(rnd() | 8'h88, 4, 4, 0, 2'h2, -1);
    i_sfpi_host.deselect();
    four = 1'b0;
    dw = sfpi_pkg::SFPI_W_SINGLE;
    frame(rnd(), 1, 1, 1, 2'h0, 3);
    i_sfpi_host.deselect();
    cmp("pause seen", 10'h001, {9'h000, saw_pause});
    rd_ph = 1'b1;
    for (int k = 0; k < 2; k++) begin
      dw = k[0] ? sfpi_pkg::SFPI_W_DUAL : sfpi_pkg::SFPI_W_SINGLE;
      rd_byte = rnd();
      frame(rnd(), 1, 1, 0, 2'h0, -1);
      cmp("selected", 10'h001, {9'h000, sel});
      i_sfpi_host.xfer(8'h00, 1 << k, 1'b1, -1, q);
      cmp("read byte", {2'h0, rd_byte}, {2'h0, q});
      i_sfpi_host.deselect();
      cmp("lines idle", 10'h000, {6'h00, dev_oe});
    end
    cmp("byte taken", 10'h001, {9'h000, saw_take});
    {rd_ph, qe} = 2'h1;
    dw = sfpi_pkg::SFPI_W_QUAD;
    frame(rnd(), 1, 4, 256, 2'h0, -1);
    cmp("overrun at page", 10'h000, {9'h000, ovr});
    // One byte past the page within the same frame
    q = rnd();
    exp_q.push_back({2'h1, q});
    i_sfpi_host.xfer(q, 4, 1'b0, -1, q);
    repeat (4) @(negedge clk);
    cmp("overrun past page", 10'h001, {9'h000, ovr});
    i_sfpi_host.deselect();
    prot.status_lock_bits = sfpi_pkg::SFPI_LOCK_HW;
    for (int k = 0; k < 4; k++) begin
      {qe, wp_lvl} = k[1:0];
      repeat (6) @(negedge clk);
      cmp("status write ok", {9'h000, k[1] | k[0]}, {9'h000, wok});
    end
    for (int r = 0; r < 8; r++) begin
      prot.protect_range = r[2:0];
      repeat (3) @(negedge clk);
      cmp("array protect", {9'h000, r != 0}, {9'h000, aprot});
    end
    busy = 1'b1;
    repeat (2) @(negedge clk);
    cmp("busy kept", 10'h001, {9'h000, busy_o});
    cmp("all bytes seen", 10'h000, 10'(exp_q.size()));
    end_sim();
  end
endmodule : testbench
